/* logic/timed_and_step_sequencer.sv */
// Module: eight-output timed and step sequencer
`timescale 1ns/1ns
// Summary of operation
// - Used outputs are a contiguous group starting at output one, up to eight.
// - Timed interval is a configured count in seconds, minutes or hours.
// - Timed mode: after trigger, one more output rises each interval, ascending.
// - Timed mode: after the last used output is set, sequencing stops, outputs hold.
// - Timed mode: reset input re-arms the sequence to start from output one.
// - Reset input drives every output to zero.
// - Timed mode: output one may be configured as held at one by default.
// - Step mode: each trigger activation sets the next output in ascending order.
// - Step mode: trigger after last output clears all; cycle restarts.
module timed_and_step_sequencer #(
  parameter int NUM_OUT = seq_pkg::NUM_OUT,
  parameter int SEC_CYCLES = seq_pkg::SEC_CYCLES,
  parameter int INTERVAL_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire seq_pkg::mode_t mode,
  input wire logic [3:0] usedOutputs,
  input wire seq_pkg::unit_t timeUnit,
  input wire logic [INTERVAL_W-1:0] interval,
  input wire logic holdFirst,
  input wire logic trigger,
  input wire logic seqReset,
  output logic [NUM_OUT-1:0] outputs,
  output logic busy
);
  if (NUM_OUT < 1 || NUM_OUT > 8) begin : g_bad_count
    $error("NUM_OUT must be 1 to 8");
  end
  if (INTERVAL_W < 1 || INTERVAL_W > 16) begin : g_bad_width
    $error("INTERVAL_W must be 1 to 16");
  end

  // ==========================================================
  // Timebase
  seq_if tickBus ();
  seq_tick #(.SEC_CYCLES(SEC_CYCLES)) uTick (.clk(clk), .rstn(rstn), .tick(tickBus));

  // ==========================================================
  // Trigger edge
  // Reset-low previous value matches the idle trigger level
  logic trigPrev;
  logic trigRise;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) trigPrev <= 1'b0;
    else trigPrev <= trigger;
  end
  assign trigRise = trigger && !trigPrev && !seqReset;

  // ==========================================================
  // Used outputs, clamped so the group stays contiguous
  function automatic logic [3:0] clampUsed(input logic [3:0] n);
    if (n == seq_pkg::COUNT_ZERO) clampUsed = 4'h1;
    else if (n > 4'(NUM_OUT)) clampUsed = 4'(NUM_OUT);
    else clampUsed = n;
  endfunction : clampUsed
  logic [3:0] lastCount;
  assign lastCount = clampUsed(usedOutputs);
  // Mask of the lowest n outputs
  function automatic logic [NUM_OUT-1:0] fillLow(input logic [3:0] n);
    fillLow = '0;
    for (int b = 0; b < NUM_OUT; b++) fillLow[b] = 4'(b) < n;
  endfunction : fillLow

  // ==========================================================
  // Unit scaling: seconds into minutes and hours
  logic [5:0] secCount;
  logic [5:0] minCount;
  logic unitTick;
  logic minTick;
  logic hourTick;
  assign minTick = tickBus.secTick && secCount == 6'(seq_pkg::SEC_PER_MIN - 1);
  assign hourTick = minTick && minCount == 6'(seq_pkg::MIN_PER_HOUR - 1);
  // Counters idle at zero so every run starts from a fresh unit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secCount <= 6'h0;
      minCount <= 6'h0;
    end else if (!busy) begin
      secCount <= 6'h0;
      minCount <= 6'h0;
    end else if (tickBus.secTick) begin
      secCount <= minTick ? 6'h0 : secCount + 6'h1;
      if (minTick) minCount <= hourTick ? 6'h0 : minCount + 6'h1;
    end
  end
  always_comb begin
    unique case (timeUnit)
      seq_pkg::UNIT_SEC: unitTick = tickBus.secTick;
      seq_pkg::UNIT_MIN: unitTick = minTick;
      seq_pkg::UNIT_HOUR: unitTick = hourTick;
      default: unitTick = tickBus.secTick;
    endcase
  end

  // ==========================================================
  // Sequencing
  logic [3:0] stage;
  logic [INTERVAL_W-1:0] unitCount;
  logic intervalDone;
  logic [INTERVAL_W-1:0] span;
  assign span = (interval == '0) ? INTERVAL_W'(1) : interval;
  // Greater-or-equal so a lowered interval cannot stall the count until wrap
  assign intervalDone = unitTick && unitCount >= span - INTERVAL_W'(1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage <= seq_pkg::COUNT_ZERO;
      busy <= 1'b0;
      unitCount <= '0;
    end else if (seqReset) begin
      stage <= seq_pkg::COUNT_ZERO;
      busy <= 1'b0;
      unitCount <= '0;
    end else if (mode == seq_pkg::MODE_TIMED) begin
      // Trigger while running or after the end is ignored until re-armed
      if (!busy && trigRise && stage == seq_pkg::COUNT_ZERO) begin
        busy <= 1'b1;
        unitCount <= '0;
      end else if (busy && unitTick) begin
        if (intervalDone) begin
          unitCount <= '0;
          stage <= stage + 4'h1;
          if (stage + 4'h1 >= lastCount) busy <= 1'b0;
        end else begin
          unitCount <= unitCount + INTERVAL_W'(1);
        end
      end
    end else begin
      busy <= 1'b0;
      unitCount <= '0;
      if (trigRise) begin
        if (stage >= lastCount) stage <= seq_pkg::COUNT_ZERO;
        else stage <= stage + 4'h1;
      end
    end
  end

  // ==========================================================
  // Output decode, registered
  // Thermometer code keeps every lower output set
  genvar i;
  generate
    for (i = 0; i < NUM_OUT; i++) begin : g_out
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) outputs[i] <= 1'b0;
        else if (seqReset) outputs[i] <= 1'b0;
        else if (i == 0 && mode == seq_pkg::MODE_TIMED && holdFirst)
          outputs[i] <= 1'b1;
        else outputs[i] <= (4'(i) < stage) && (4'(i) < lastCount);
      end
    end
  endgenerate

  // ==========================================================
  // Check helpers
  // Cycles since the last timed step, counted in seconds mode only:
  // longer units would need a far wider window to bound
  logic [47:0] stepAge;
  logic [INTERVAL_W-1:0] prevInterval;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prevInterval <= '0;
    else prevInterval <= interval;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stepAge <= 48'h0;
    end else if (!busy || intervalDone || seqReset || timeUnit != seq_pkg::UNIT_SEC
        || interval != prevInterval) begin
      stepAge <= 48'h0;
    end else begin
      stepAge <= stepAge + 48'h1;
    end
  end

  // ==========================================================
  // Checks
  a_reset_clears: assert property (@(posedge clk) disable iff (!rstn)
    seqReset |=> outputs == '0) else $error("reset input did not clear outputs");
  a_step_advance: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_STEP && trigRise && stage < lastCount && !$past(seqReset)
    |=> stage == $past(stage) + 4'h1) else $error("step did not advance");
  a_step_wrap: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_STEP && trigRise && stage >= lastCount
    |=> stage == seq_pkg::COUNT_ZERO) else $error("step did not wrap");
  a_timed_stops: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_TIMED && !busy && stage >= lastCount && !seqReset
    && !trigRise ##1 mode == seq_pkg::MODE_TIMED |-> !busy && $stable(stage))
    else $error("timed sequence moved after the end");
  a_timed_step_one: assert property (@(posedge clk) disable iff (!rstn)
    busy && intervalDone && !seqReset && mode == seq_pkg::MODE_TIMED
    |=> stage == $past(stage) + 4'h1) else $error("timed stage not advanced");
  a_rearm_zero: assert property (@(posedge clk) disable iff (!rstn)
    seqReset |=> stage == seq_pkg::COUNT_ZERO && !busy) else $error("not re-armed");
  a_contig_group: assert property (@(posedge clk) disable iff (!rstn)
    ((outputs + 1'b1) & outputs) == '0) else $error("outputs not contiguous");
  a_reset_priority: assert property (@(posedge clk) disable iff (!rstn)
    seqReset && trigger && !trigPrev |=> stage == seq_pkg::COUNT_ZERO)
    else $error("trigger beat reset");
  a_unit_select: assert property (@(posedge clk) disable iff (!rstn)
    timeUnit == seq_pkg::UNIT_SEC |-> unitTick == tickBus.secTick)
    else $error("second unit mismatch");
  a_hold_first: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_TIMED && holdFirst && !seqReset |=> outputs[0])
    else $error("first output not held");

  // Timing bound, busy and start control, idle counters and decode
  a_step_deadline: assert property (@(posedge clk) disable iff (!rstn)
    busy |-> stepAge < 48'(span) * 48'(SEC_CYCLES))
    else $error("timed step overdue");
  a_step_no_busy: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_STEP |=> !busy) else $error("busy in step mode");
  a_timed_start: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_TIMED && trigRise && !busy && stage == seq_pkg::COUNT_ZERO
    |=> busy) else $error("timed sequence did not start");
  a_busy_ignores: assert property (@(posedge clk) disable iff (!rstn)
    mode == seq_pkg::MODE_TIMED && busy && trigRise && !intervalDone
    |=> busy && $stable(stage)) else $error("trigger disturbed running sequence");
  a_idle_counts: assert property (@(posedge clk) disable iff (!rstn)
    !busy |=> secCount == 6'h0 && minCount == 6'h0) else $error("unit counters not idle");
  a_out_follow: assert property (@(posedge clk) disable iff (!rstn)
    !seqReset && !(mode == seq_pkg::MODE_TIMED && holdFirst)
    |=> outputs == fillLow($past(stage < lastCount ? stage : lastCount)))
    else $error("outputs do not follow stage");
endmodule : timed_and_step_sequencer

/* logic/seq_pkg.sv */
// Package: constants and types shared by the sequencer files
package seq_pkg;
  localparam int NUM_OUT = 8;
  localparam int CLK_HZ = 20_000_000;
  // Timebase: one tick per second
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_TIME_S;
  localparam int SEC_PER_MIN = 60;
  localparam int MIN_PER_HOUR = 60;
  typedef enum logic [1:0] {UNIT_SEC, UNIT_MIN, UNIT_HOUR} unit_t;
  typedef enum logic {MODE_TIMED, MODE_STEP} mode_t;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
endpackage : seq_pkg

/* logic/seq_if.sv */
// Interface: timebase tick passed from the tick generator to the sequencer
`timescale 1ns/1ns
interface seq_if;
  logic secTick;
  modport gen (output secTick);
  modport use_side (input secTick);
endinterface : seq_if

/* logic/seq_tick.sv */
// Module: one-second timebase tick generator
`timescale 1ns/1ns
module seq_tick #(
  parameter int SEC_CYCLES = seq_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  seq_if.gen tick
);
  if (SEC_CYCLES < 2) begin : g_bad_period
    $error("SEC_CYCLES too small");
  end
  logic [31:0] count;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
      tick.secTick <= 1'b0;
    end else if (count == 32'(SEC_CYCLES - 1)) begin
      count <= 32'h0;
      tick.secTick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick.secTick <= 1'b0;
    end
  end
endmodule : seq_tick

/* tb/seq_source.sv */
// Model of the upstream logic that drives trigger and block reset
`timescale 1ns/1ns
module seq_source (
  input wire logic clk,
  output logic trigger,
  output logic seqReset
);
  initial begin
    trigger = 1'b0;
    seqReset = 1'b0;
  end
  // Trigger stays low at least one edge between rises
  task automatic fire(input int gap);
    @(negedge clk);
    trigger = 1'b1;
    @(negedge clk);
    trigger = 1'b0;
    repeat (gap) @(negedge clk);
  endtask : fire
  task automatic clear(input logic withTrig);
    @(negedge clk);
    seqReset = 1'b1;
    trigger = withTrig;
    repeat (2) @(negedge clk);
    seqReset = 1'b0;
    trigger = 1'b0;
    repeat (2) @(negedge clk);
  endtask : clear
endmodule : seq_source

/* tb/timed_and_step_sequencer_bench.sv */
// Self-checking bench for the timed and step sequencer
`timescale 1ns/1ns
module timed_and_step_sequencer_bench;
  // Short second keeps the run brief
  localparam int SEC = 20;
  logic clk;
  logic rstn;
  seq_pkg::mode_t mode;
  logic [3:0] usedOutputs;
  seq_pkg::unit_t timeUnit;
  logic [7:0] interval;
  logic holdFirst;
  logic trigger;
  logic seqReset;
  logic [7:0] outputs;
  logic busy;
  int error_cnt;
  int comparisons;
  int seed;
  int used;
  int n;
  timed_and_step_sequencer #(.SEC_CYCLES(SEC)) u_timed_and_step_sequencer (
    .clk(clk), .rstn(rstn), .mode(mode), .usedOutputs(usedOutputs),
    .timeUnit(timeUnit), .interval(interval), .holdFirst(holdFirst),
    .trigger(trigger), .seqReset(seqReset), .outputs(outputs), .busy(busy));
  seq_source u_seq_source (.clk(clk), .trigger(trigger), .seqReset(seqReset));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ====
  // Helpers
  function automatic logic [7:0] therm(input int k);
    logic [8:0] v;
    v = (9'h1 << k) - 9'h1;
    return v[7:0];
  endfunction : therm
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic check_span(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask : check_span
  task automatic wait_change(input logic [7:0] prev, input int limit, output int cyc);
    cyc = 0;
    while (outputs === prev && cyc < limit) begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= limit) begin
      error_cnt++;
      $display("Error at %0t: no output change", $time);
      close_out();
    end
  endtask : wait_change
  // ====
  // Main sequence
  initial begin
    seed = 24;
    error_cnt = 0;
    comparisons = 0;
    rstn = 1'b0;
    mode = seq_pkg::MODE_STEP;
    usedOutputs = 4'h8;
    timeUnit = seq_pkg::UNIT_SEC;
    interval = 8'h01;
    holdFirst = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    check(outputs, 8'h00);
    for (int r = 0; r < 5; r++) begin
      used = (r == 0) ? 8 : 1 + $unsigned($random(seed)) % 8;
      usedOutputs = 4'(used);
      holdFirst = 1'($random(seed));
      timeUnit = seq_pkg::unit_t'(2'($unsigned($random(seed)) % 3));
      for (int k = 1; k <= used + 1; k++) begin
        u_seq_source.fire(2 + $unsigned($random(seed)) % 3);
        check(outputs, therm(k % (used + 1)));
      end
    end
    usedOutputs = 4'h8;
    u_seq_source.fire(2);
    u_seq_source.fire(2);
    u_seq_source.clear(1'b1);
    check(outputs, 8'h00);
    u_seq_source.fire(2);
    check(outputs, 8'h01);
    u_seq_source.clear(1'($random(seed)));
    holdFirst = 1'b0;
    timeUnit = seq_pkg::UNIT_SEC;
    mode = seq_pkg::MODE_TIMED;
    for (int r = 0; r < 2; r++) begin
      used = (r == 0) ? 8 : 1 + $unsigned($random(seed)) % 8;
      usedOutputs = 4'(used);
      interval = 8'(1 + $unsigned($random(seed)) % 3);
      u_seq_source.fire(1);
      check_flag(busy, 1'b1);
      if (r == 1) u_seq_source.fire(1);
      for (int k = 1; k <= used; k++) begin
        wait_change(therm(k - 1), 8 * SEC, n);
        check(outputs, therm(k));
        if (k > 1) check_span(n, interval * SEC, interval * SEC);
      end
      u_seq_source.fire(interval * SEC + 4);
      check(outputs, therm(used));
      check_flag(busy, 1'b0);
      u_seq_source.clear(1'b0);
      check(outputs, 8'h00);
    end
    usedOutputs = 4'h1;
    interval = 8'h01;
    timeUnit = seq_pkg::UNIT_MIN;
    u_seq_source.fire(0);
    wait_change(8'h00, 61 * SEC + 4, n);
    check_span(n, 59 * SEC, 60 * SEC + 2);
    u_seq_source.clear(1'b0);
    timeUnit = seq_pkg::UNIT_HOUR;
    u_seq_source.fire(0);
    wait_change(8'h00, 3601 * SEC + 4, n);
    check_span(n, 3599 * SEC, 3600 * SEC + 2);
    u_seq_source.clear(1'b0);
    holdFirst = 1'b1;
    repeat (2) @(negedge clk);
    check(outputs, 8'h01);
    close_out();
  end
endmodule : timed_and_step_sequencer_bench
